// ==== plcs_pkg.sv ====
// Constants shared by the port loopback and crossover status block.
// Assumes APB with 32-bit data; register indices map to byte address index*4.
`default_nettype none
package plcs_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NPORT = 5;
  localparam int unsigned NSTAT = 4;
  localparam int unsigned AW = 12;
  localparam int unsigned DW = 32;
  localparam int unsigned IDX_W = 7;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned PORT_W = 3;
  localparam int unsigned BYTE_W = 8;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [6:0] CTRL_IDX [0:4] = '{7'h1D, 7'h2D, 7'h3D, 7'h4D, 7'h5D};
  localparam logic [6:0] STAT_IDX [0:3] = '{7'h1E, 7'h2E, 7'h3E, 7'h4E};
  localparam logic [6:0] RSVD_IDX = 7'h5E;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned TURN_BIT = 0;
  localparam int unsigned FSTR_BIT = 1;
  localparam int unsigned AUTO_OFF_BIT = 2;
  localparam int unsigned XSTATE_BIT = 7;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic TURN_RST = 1'h0;
  localparam logic FSTR_RST = 1'h0;
  localparam logic AUTO_OFF_RST = 1'h0;
  localparam logic XSTATE_RST = 1'h0;
  localparam logic [31:0] RDATA_RST = 32'h00000000;

endpackage : plcs_pkg
`default_nettype wire

// ==== plcs_steer_if.sv ====
// Carrier between the register block and the frame turnaround steering.
// Assumes both ends run on the one core clock.
`timescale 1ns/1ps
`default_nettype none
interface plcs_steer_if;
  logic [4:0] turn_en;   // Per-port turnaround enable
  logic in_valid;        // Forwarded beat valid
  logic [2:0] in_src;    // Ingress port of the frame
  logic [2:0] in_dst;    // Chosen egress port
  logic [7:0] in_data;   // Frame byte
  logic in_last;         // Last byte of frame
  logic out_valid;       // Steered beat valid
  logic [2:0] out_port;  // Port the beat leaves on
  logic [7:0] out_data;  // Frame byte
  logic out_last;        // Last byte of frame
  logic out_turned;      // Beat was turned around

  modport ctrl (output turn_en, in_valid, in_src, in_dst, in_data, in_last,
                input out_valid, out_port, out_data, out_last, out_turned);
  modport steer (input turn_en, in_valid, in_src, in_dst, in_data, in_last,
                 output out_valid, out_port, out_data, out_last, out_turned);
endinterface : plcs_steer_if
`default_nettype wire

// ==== plcs_turnaround.sv ====
// Frame steering: sends frames bound for a turned-around port back out
// of the port they came in on. Assumes in_src/in_dst hold for a frame.
`timescale 1ns/1ps
`default_nettype none
module plcs_turnaround (
  input wire logic clk_i,      // Core clock
  input wire logic srst_i,     // Synchronous reset, active high
  plcs_steer_if.steer sif      // Steering carrier
);

  logic mid_q;
  logic mid_d;
  logic turn_q;
  logic turn_now;
  logic turn_use;

  // ----------------------------------------------------------------
  // Turnaround decision
  // ----------------------------------------------------------------
  // decide at first byte
  assign turn_now = (sif.in_dst < plcs_pkg::PORT_W'(plcs_pkg::NPORT))
                    && sif.turn_en[sif.in_dst] && (sif.in_src != sif.in_dst);
  // Keep one decision for the whole frame so it never splits
  assign turn_use = mid_q ? turn_q : turn_now;
  assign mid_d = sif.in_valid ? !sif.in_last : mid_q;

  // Frame tracking
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      mid_q <= 1'b0;
      turn_q <= 1'b0;
    end
    else
    begin
      mid_q <= mid_d;
      if (sif.in_valid && !mid_q)
      begin
        turn_q <= turn_now;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sif.out_valid <= 1'b0;
      sif.out_port <= 3'h0;
      sif.out_data <= 8'h00;
      sif.out_last <= 1'b0;
      sif.out_turned <= 1'b0;
    end
    else
    begin
      sif.out_valid <= sif.in_valid;
      sif.out_port <= turn_use ? sif.in_src : sif.in_dst;
      sif.out_data <= sif.in_data;
      sif.out_last <= sif.in_last;
      sif.out_turned <= sif.in_valid && turn_use;
    end
  end

endmodule : plcs_turnaround
`default_nettype wire

// ==== plcs_top.sv ====
// Per-port MAC turnaround control and crossover mode/status registers
// of a five-port switch, reached over APB.
// Assumes the auto-crossover result arrives asynchronously from the PHYs
// and the forwarded frame stream runs on the core clock.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - First port control bit 0 at index 29 puts its MAC in turnaround.
// - Frames from a monitor port to a turned port go back out the monitor.
// - Bit 0 at indices 45, 61, 77, 93 turns ports two to five.
// - Turnaround bit resets to zero, is read/write; zero means normal forwarding.
// - Status registers for ports one to four at 0x1E, 0x2E, 0x3E, 0x4E.
// - Index 0x5E is reserved and carries no status.
// - Status bit 7 is read-only, resets zero, one means straight wiring.
// - Control bit 2 at zero, its reset value, keeps automatic crossover on.
// - With automatic off, control bit 1 forces straight (one) or crossed (zero).
module plcs_top (
  input wire logic clk_i,               // Core clock, 100 MHz
  input wire logic srst_i,              // Synchronous reset, active high
  input wire logic psel_i,              // APB select
  input wire logic penable_i,           // APB enable
  input wire logic pwrite_i,            // APB direction, high for write
  input wire logic [11:0] paddr_i,      // APB byte address
  input wire logic [31:0] pwdata_i,     // APB write data
  input wire logic [3:0] pstrb_i,       // APB byte strobes
  output logic [31:0] prdata_o,         // APB read data
  output logic pready_o,                // APB ready
  output logic pslverr_o,               // APB error on unmapped address
  input wire logic [4:0] auto_straight_i, // Auto crossover result per port
  input wire logic fwd_valid_i,         // Forwarded byte valid
  input wire logic [2:0] fwd_src_i,     // Ingress port of frame
  input wire logic [2:0] fwd_dst_i,     // Egress port chosen by lookup
  input wire logic [7:0] fwd_data_i,    // Frame byte
  input wire logic fwd_last_i,          // Last byte of frame
  output logic eg_valid_o,              // Egress byte valid
  output logic [2:0] eg_port_o,         // Egress port
  output logic [7:0] eg_data_o,         // Egress byte
  output logic eg_last_o,               // Egress last byte
  output logic eg_turned_o,             // Egress byte was turned around
  output logic [4:0] straight_o,        // Wiring mode in effect, one straight
  output logic [4:0] turnaround_o       // Turnaround enable per port
);

  // ----------------------------------------------------------------
  // Address decoding helpers
  // ----------------------------------------------------------------

  // One-hot port select of a control register index
  function automatic logic [4:0] plcs_ctrl_sel(input logic [6:0] idx);
    logic [4:0] sel;
    sel = 5'h00;
    for (int p = 0; p < plcs_pkg::NPORT; p++)
    begin
      sel[p] = (idx == plcs_pkg::CTRL_IDX[p]);
    end
    return sel;
  endfunction : plcs_ctrl_sel

  // One-hot port select of a status register index
  function automatic logic [3:0] plcs_stat_sel(input logic [6:0] idx);
    logic [3:0] sel;
    sel = 4'h0;
    for (int p = 0; p < plcs_pkg::NSTAT; p++)
    begin
      sel[p] = (idx == plcs_pkg::STAT_IDX[p]);
    end
    return sel;
  endfunction : plcs_stat_sel

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  plcs_steer_if sif ();

  logic [6:0] idx;
  logic addr_ok;
  logic [4:0] ctrl_hit;
  logic [3:0] stat_hit;
  logic rsvd_hit;
  logic mapped;
  logic acc;
  logic fire;
  logic wr_fire;
  logic [31:0] rd_val;

  logic [4:0] turn_q;
  logic [4:0] fstr_q;
  logic [4:0] auto_off_q;
  logic [4:0] mode_q;
  logic [4:0] mode_d;

  logic [4:0] sy1_q;
  logic [4:0] sy2_q;
  logic [4:0] sy3_q;
  logic [4:0] auto_q;

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------

  // Word index and alignment; bits above the index must be zero
  assign idx = paddr_i[8:2];
  assign addr_ok = (paddr_i[1:0] == 2'h0) && (paddr_i[11:9] == 3'h0);
  assign ctrl_hit = addr_ok ? plcs_ctrl_sel(idx) : 5'h00;
  assign stat_hit = addr_ok ? plcs_stat_sel(idx) : 4'h0;
  assign rsvd_hit = addr_ok && (idx == plcs_pkg::RSVD_IDX);
  assign mapped = (|ctrl_hit) || (|stat_hit) || rsvd_hit;

  // Access phase, and the edge at which the transfer completes
  assign acc = psel_i && penable_i;
  assign fire = acc && pready_q;
  // Only the low byte lane holds register bits
  assign wr_fire = fire && pwrite_i && pstrb_i[0];

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------

  // Narrow registers sit in the low bits; all else reads zero
  always_comb
  begin
    rd_val = plcs_pkg::RDATA_RST;
    for (int p = 0; p < plcs_pkg::NPORT; p++)
    begin
      if (ctrl_hit[p])
      begin
        rd_val[plcs_pkg::TURN_BIT] = turn_q[p];
        rd_val[plcs_pkg::FSTR_BIT] = fstr_q[p];
        rd_val[plcs_pkg::AUTO_OFF_BIT] = auto_off_q[p];
      end
    end
    for (int p = 0; p < plcs_pkg::NSTAT; p++)
    begin
      if (stat_hit[p])
      begin
        rd_val[plcs_pkg::XSTATE_BIT] = mode_q[p];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------

  // One wait state: ready rises on the second access cycle
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= plcs_pkg::RDATA_RST;
    end
    else if (acc && !pready_q)
    begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped;
      prdata_q <= pwrite_i ? plcs_pkg::RDATA_RST : rd_val;
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= plcs_pkg::RDATA_RST;
    end
  end

  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign prdata_o = prdata_q;

  // ----------------------------------------------------------------
  // Control registers, one per port
  // ----------------------------------------------------------------
  for (genvar p = 0; p < plcs_pkg::NPORT; p++)
  begin : g_ctrl
    always_ff @(posedge clk_i)
    begin
      if (srst_i)
      begin
        turn_q[p] <= plcs_pkg::TURN_RST;
        fstr_q[p] <= plcs_pkg::FSTR_RST;
        auto_off_q[p] <= plcs_pkg::AUTO_OFF_RST;
      end
      else if (wr_fire && ctrl_hit[p])
      begin
        turn_q[p] <= pwdata_i[plcs_pkg::TURN_BIT];
        fstr_q[p] <= pwdata_i[plcs_pkg::FSTR_BIT];
        auto_off_q[p] <= pwdata_i[plcs_pkg::AUTO_OFF_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Auto crossover result synchroniser
  // ----------------------------------------------------------------

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sy1_q <= 5'h00;
      sy2_q <= 5'h00;
      sy3_q <= 5'h00;
    end
    else
    begin
      sy1_q <= auto_straight_i;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  for (genvar p = 0; p < plcs_pkg::NPORT; p++)
  begin : g_filt
    // Hold the last agreed value while the stages disagree
    always_ff @(posedge clk_i)
    begin
      if (srst_i)
      begin
        auto_q[p] <= plcs_pkg::XSTATE_RST;
      end
      else if (sy2_q[p] == sy3_q[p])
      begin
        auto_q[p] <= sy3_q[p];
      end
    end
  end

  // ----------------------------------------------------------------
  // Wiring mode in effect
  // ----------------------------------------------------------------

  assign mode_d = (auto_off_q & fstr_q) | (~auto_off_q & auto_q);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      mode_q <= {plcs_pkg::NPORT{plcs_pkg::XSTATE_RST}};
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  assign straight_o = mode_q;
  assign turnaround_o = turn_q;

  // ----------------------------------------------------------------
  // Frame turnaround steering
  // ----------------------------------------------------------------

  // Feed the steering stage with the forwarded stream
  assign sif.turn_en = turn_q;
  assign sif.in_valid = fwd_valid_i;
  assign sif.in_src = fwd_src_i;
  assign sif.in_dst = fwd_dst_i;
  assign sif.in_data = fwd_data_i;
  assign sif.in_last = fwd_last_i;

  plcs_turnaround u_turn (
    .clk_i (clk_i),
    .srst_i (srst_i),
    .sif (sif.steer)
  );

  // Egress outputs come from the steering flip-flops
  assign eg_valid_o = sif.out_valid;
  assign eg_port_o = sif.out_port;
  assign eg_data_o = sif.out_data;
  assign eg_last_o = sif.out_last;
  assign eg_turned_o = sif.out_turned;

endmodule : plcs_top
`default_nettype wire

// ==== plcs_top_assertions.sv ====
// Checker for the port turnaround and crossover register block.
// Assumes it is bound to plcs_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module plcs_top_assertions (
  input wire logic clk_i, // Clock
  input wire logic srst_i, // Reset
  input wire logic psel_i, // APB
  input wire logic penable_i, // APB
  input wire logic pwrite_i, // APB
  input wire logic [11:0] paddr_i, // APB
  input wire logic [31:0] pwdata_i, // APB
  input wire logic [3:0] pstrb_i, // APB
  input wire logic [31:0] prdata_o, // APB
  input wire logic pready_o, // APB
  input wire logic pslverr_o, // APB
  input wire logic fwd_valid_i, // Stream in
  input wire logic [2:0] fwd_src_i, // Stream in
  input wire logic [2:0] fwd_dst_i, // Stream in
  input wire logic eg_valid_o, // Stream out
  input wire logic [2:0] eg_port_o, // Stream out
  input wire logic eg_turned_o, // Stream out
  input wire logic [4:0] straight_o, // Mode
  input wire logic [4:0] turnaround_o // Turnaround
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // Completed transfers and turned frames
  wire logic acc = psel_i && penable_i && pready_o;
  wire logic rd = acc && !pwrite_i;
  wire logic wr = acc && pwrite_i && pstrb_i[0];
  wire logic turned = fwd_valid_i && fwd_dst_i < 3'h5 && turnaround_o[fwd_dst_i] && fwd_src_i != fwd_dst_i;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_one_wait: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
    else $error("ready not after one wait state");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  chk_turn_first: assert property (wr && paddr_i == 12'h074 |=> turnaround_o[0] == $past(pwdata_i[0]))
    else $error("first port turnaround wrong");
  chk_turn_fifth: assert property (wr && paddr_i == 12'h174 |=> turnaround_o[4] == $past(pwdata_i[0]))
    else $error("fifth port turnaround wrong");
  chk_ctrl_read: assert property (rd && paddr_i == 12'h0B4 |-> prdata_o[0] == turnaround_o[1] && prdata_o[31:3] == 29'h0)
    else $error("control read wrong");
  chk_status_bit: assert property (rd && paddr_i == 12'h0F8 |-> prdata_o == {24'h0, $past(straight_o[2]), 7'h00})
    else $error("status read wrong");
  chk_rsvd_zero: assert property (rd && paddr_i == 12'h178 |-> prdata_o == 32'h0 && !pslverr_o)
    else $error("reserved read wrong");
  chk_forced_mode: assert property (wr && paddr_i == 12'h074 && pwdata_i[2] |=> ##1 straight_o[0] == $past(pwdata_i[1], 2))
    else $error("forced mode wrong");
  chk_loop_back: assert property (turned |=> eg_valid_o && eg_turned_o && eg_port_o == $past(fwd_src_i))
    else $error("frame not turned around");
  chk_normal_fwd: assert property (fwd_valid_i && turnaround_o == 5'h00 |=> eg_valid_o && !eg_turned_o && eg_port_o == $past(fwd_dst_i))
    else $error("frame not forwarded");
endmodule : plcs_top_assertions
bind plcs_top plcs_top_assertions u_chk (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .fwd_valid_i(fwd_valid_i), .fwd_src_i(fwd_src_i),
  .fwd_dst_i(fwd_dst_i), .eg_valid_o(eg_valid_o), .eg_port_o(eg_port_o), .eg_turned_o(eg_turned_o),
  .straight_o(straight_o), .turnaround_o(turnaround_o));
`default_nettype wire

// ==== tb_top.sv ====
// Testbench for the port turnaround and crossover register block.
// Assumes plcs_top with one APB wait state and a one-cycle stream.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'h0;
  logic srst_i = 1'h1;
  logic psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0, fwd_valid_i = 1'h0, fwd_last_i = 1'h0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rdat, seed = 32'hD258;
  logic [4:0] auto_straight_i = 5'h00, straight_o, turnaround_o;
  logic [2:0] fwd_src_i = 3'h0, fwd_dst_i = 3'h0, eg_port_o, ctl [0:4];
  logic [7:0] fwd_data_i = 8'h00, eg_data_o;
  logic pready_o, pslverr_o, eg_valid_o, eg_last_o, eg_turned_o, rerr;
  int mismatches = 0, checks = 0;
  // Core clock
  always #5 clk_i = ~clk_i;
  plcs_top dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hF), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .auto_straight_i(auto_straight_i), .fwd_valid_i(fwd_valid_i), .fwd_src_i(fwd_src_i),
    .fwd_dst_i(fwd_dst_i), .fwd_data_i(fwd_data_i), .fwd_last_i(fwd_last_i), .eg_valid_o(eg_valid_o),
    .eg_port_o(eg_port_o), .eg_data_o(eg_data_o), .eg_last_o(eg_last_o), .eg_turned_o(eg_turned_o),
    .straight_o(straight_o), .turnaround_o(turnaround_o));
  // ----------------------------------------------------------------
  // Expectations and helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic [4:0] mode_exp();
    logic [4:0] m;
    for (int p = 0; p < 5; p++) m[p] = ctl[p][2] ? ctl[p][1] : auto_straight_i[p];
    return m;
  endfunction : mode_exp
  function automatic logic [31:0] exp_rd(input logic [11:0] a);
    logic [4:0] m;
    m = mode_exp();
    for (int p = 0; p < 5; p++)
    begin
      if (a == 12'h074 + 12'(p * 64)) return {29'h0, ctl[p]};
      if (p < 4 && a == 12'h078 + 12'(p * 64)) return {24'h0, m[p], 7'h00};
    end
    return 32'h0;
  endfunction : exp_rd
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_o !== 1'h1 && n < 50);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    if (n >= 50)
    begin
      $display("wrong value pready expected 1 seen 0");
      mismatches++;
      finish_test();
    end
  endtask : apb
  task automatic reg_wr(input int p, input logic [31:0] v);
    apb(1'h1, 12'h074 + 12'(p * 64), v);
    ctl[p] = v[2:0];
    chk("write error", 32'h0, {31'h0, rerr});
  endtask : reg_wr
  task automatic reg_rd(input logic [11:0] a, input logic e);
    apb(1'h0, a, 32'h0);
    chk("read data", exp_rd(a), rdat);
    chk("read error", {31'h0, e}, {31'h0, rerr});
  endtask : reg_rd
  task automatic frame(input logic [2:0] s, input logic [2:0] d, input logic [2:0] ep, input logic t);
    logic [7:0] b;
    seed = nxt(seed);
    b = seed[7:0];
    @(posedge clk_i);
    fwd_valid_i <= 1'h1;
    fwd_src_i <= s;
    fwd_dst_i <= d;
    fwd_data_i <= b;
    fwd_last_i <= 1'h1;
    @(posedge clk_i);
    fwd_valid_i <= 1'h0;
    #1;
    chk("egress valid", 32'h1, {31'h0, eg_valid_o});
    chk("egress port", {29'h0, ep}, {29'h0, eg_port_o});
    chk("egress turned", {31'h0, t}, {31'h0, eg_turned_o});
    chk("egress data", {24'h0, b}, {24'h0, eg_data_o});
    chk("egress last", 32'h1, {31'h0, eg_last_o});
  endtask : frame
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    finish_test();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    for (int p = 0; p < 5; p++) ctl[p] = 3'h0;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'h0;
    for (int p = 0; p < 5; p++)
    begin
      reg_rd(12'h074 + 12'(p * 64), 1'h0);
      reg_rd(12'h078 + 12'(p * 64), 1'h0);
    end
    $display("test reset_values done");
    apb(1'h1, 12'h078, 32'hFF);
    reg_rd(12'h078, 1'h0);
    apb(1'h1, 12'h178, 32'hFF);
    reg_rd(12'h178, 1'h0);
    reg_rd(12'h000, 1'h1);
    reg_rd(12'h075, 1'h1);
    reg_rd(12'h07C, 1'h1);
    $display("test odd_access done");
    for (int i = 0; i < 24; i++)
    begin
      seed = nxt(seed);
      auto_straight_i <= seed[12:8];
      reg_wr(seed[18:16] % 5, seed[7:0]);
      repeat (8) @(posedge clk_i);
      chk("mode", {27'h0, mode_exp()}, {27'h0, straight_o});
      chk("turnaround", {27'h0, ctl[4][0], ctl[3][0], ctl[2][0], ctl[1][0], ctl[0][0]}, {27'h0, turnaround_o});
      reg_rd(12'h074 + 12'((seed[18:16] % 5) * 64), 1'h0);
      reg_rd(12'h078 + 12'((seed[26:24] % 5) * 64), 1'h0);
    end
    $display("test random_modes done");
    for (int p = 0; p < 5; p++) reg_wr(p, {31'h0, p == 0});
    frame(3'h1, 3'h0, 3'h1, 1'h1);
    frame(3'h4, 3'h0, 3'h4, 1'h1);
    frame(3'h0, 3'h0, 3'h0, 1'h0);
    frame(3'h2, 3'h5, 3'h5, 1'h0);
    reg_wr(0, 32'h0);
    frame(3'h1, 3'h0, 3'h0, 1'h0);
    $display("test turnaround_stream done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
